// ---- rtl/lcd_ctrl_pkg.sv ----
// Purpose: constants for the display driver enable control block
// Assumes: 32-bit classic Wishbone register bus, byte addresses
// Notes:   register offsets are word aligned
package lcd_ctrl_pkg;

  // ==========================================================
  // register offsets
  localparam logic [7:0] power_off_control_two_off = 8'h00;
  localparam logic [7:0] display_control_one_off   = 8'h04;
  localparam logic [7:0] display_control_two_off   = 8'h08;
  localparam logic [7:0] port_segment_select_off   = 8'h0C;
  localparam logic [7:0] system_control_two_off    = 8'h10;
  localparam logic [7:0] status_off                = 8'h14;

  // ==========================================================
  // field positions
  localparam int gate_bit      = 0;
  localparam int enable_bit    = 7;
  localparam int duty_lsb      = 4;
  localparam int duty_w        = 3;
  localparam int slf_lsb       = 0;
  localparam int slf_w         = 4;
  localparam int lrse_lsb      = 5;
  localparam int lrse_w        = 3;
  localparam int brh_bit       = 4;
  localparam int bias_sel_bit  = 3;
  localparam int high_osc_bit  = 0;
  localparam int int_osc_bit   = 1;
  localparam int low_osc_bit   = 2;

  // ==========================================================
  // reset values and the control two read mask
  localparam logic [7:0] control_one_rst = 8'h00;
  localparam logic [7:0] control_two_rst = 8'h00;
  localparam logic [7:0] sysctl_rst      = 8'h00;
  localparam logic [7:0] ctl_two_rd_mask = 8'hF8;

  // base frequency codes
  localparam logic [3:0] slf_gear_max = 4'h6;
  localparam logic [3:0] slf_low_min  = 4'h8;
  localparam logic [3:0] slf_low_max  = 4'h9;

  // drive methods
  typedef enum logic [2:0] {
    quarter_third = 3'b000,
    third_third   = 3'b001,
    third_half    = 3'b010,
    half_half     = 3'b011,
    static_drive  = 3'b100
  } drive_method_type;

  // display power sequencer
  typedef enum logic [1:0] {
    st_off     = 2'b00,
    st_wait    = 2'b01,
    st_on      = 2'b10
  } power_state_type;

endpackage

// ---- rtl/lcd_reg_word.sv ----
// Purpose: one byte-wide control register with per-bit write mask
// Assumes: synchronous active-high reset
// Notes:   read data comes straight from the register
`timescale 1ns/1ps
module lcd_reg_word
#(
  parameter int          WIDTH = 8,
  parameter logic [7:0]  RST   = 8'h00,
  parameter logic [7:0]  WMASK = 8'hFF
)
(
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // write port
  input  wire logic             we_i,
  input  wire logic [WIDTH-1:0] wdata_i,
  // hardware clear of selected bits
  input  wire logic [WIDTH-1:0] hw_clr_i,
  // value
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] q_reg;
  logic [WIDTH-1:0] q_next;

  // hardware clear beats a software write in the same cycle
  assign q_next = ((we_i ? (wdata_i & WMASK[WIDTH-1:0]) : q_reg)) & ~hw_clr_i;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      q_reg <= RST[WIDTH-1:0];
    else
      q_reg <= q_next;
  end

  assign q_o = q_reg;

endmodule

// ---- rtl/lcd_enable_ctrl.sv ----
// Purpose: clock gate, display power and pin-function control of a segment display driver
// Assumes: classic Wishbone slave, 32-bit data, byte addresses, 25 MHz clk_i
// Notes:   waveform generation and frame division live elsewhere
`timescale 1ns/1ps
module lcd_enable_ctrl
  import lcd_ctrl_pkg::*;
#(
  parameter int SEG_PINS  = 40,
  parameter int COM_PINS  = 4,
  parameter int BIAS_PINS = 2
)
(
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // wishbone slave
  input  wire logic                 cyc_i,
  input  wire logic                 stb_i,
  input  wire logic                 we_i,
  input  wire logic [7:0]           adr_i,
  input  wire logic [3:0]           sel_i,
  input  wire logic [31:0]          dat_i,
  output logic      [31:0]          dat_o,
  output logic                      ack_o,
  output logic                      err_o,
  // clock controller
  input  wire logic                 deep_idle_mode_i,
  input  wire logic                 deep_sleep_mode_i,
  input  wire logic                 stop_mode_i,
  input  wire logic                 high_clk_running_i,
  input  wire logic                 low_clk_running_i,
  input  wire logic                 base_clk_i,
  // driver core
  output logic                      driver_clk_o,
  output logic                      drive_supply_on_o,
  output logic                      display_active_o,
  output logic      [2:0]           drive_method_o,
  output logic                      drive_method_valid_o,
  output logic      [3:0]           base_sel_o,
  output logic      [2:0]           low_res_time_o,
  output logic                      high_res_sel_o,
  output logic                      internal_bias_o,
  input  wire logic [COM_PINS-1:0]  com_wave_i,
  input  wire logic [SEG_PINS-1:0]  seg_wave_i,
  // common pins
  output logic      [COM_PINS-1:0]  com_o,
  // shared segment / port pins
  input  wire logic [SEG_PINS-1:0]  port_out_i,
  input  wire logic [SEG_PINS-1:0]  port_oe_n_i,
  output logic      [SEG_PINS-1:0]  seg_o,
  output logic      [SEG_PINS-1:0]  seg_oe_n_o,
  // bias-capable shared pins
  input  wire logic [BIAS_PINS-1:0] bias_port_out_i,
  input  wire logic [BIAS_PINS-1:0] bias_port_oe_n_i,
  output logic      [BIAS_PINS-1:0] bias_o,
  output logic      [BIAS_PINS-1:0] bias_oe_n_o,
  output logic      [BIAS_PINS-1:0] bias_ext_conn_o
);

  // ==========================================================
  // helpers
  // reserved base codes belong to neither source, so they never light the display
  function automatic logic slf_is_gear(input logic [3:0] code);
    return code <= slf_gear_max;
  endfunction

  function automatic logic slf_is_low(input logic [3:0] code);
    return (code >= slf_low_min) && (code <= slf_low_max);
  endfunction

  // ==========================================================
  // bus decode
  logic        req;
  logic        ack_reg;
  logic        wr_stb;
  logic        hit_gate;
  logic        hit_one;
  logic        hit_two;
  logic        hit_port;
  logic        hit_sys;
  logic        hit_stat;
  logic        hit_any;
  logic        lane0_wr;
  logic        gate_we;
  logic        one_we;
  logic        two_we;
  logic        sys_we;
  logic        port_we;

  // one-cycle answer, dropped the cycle after; a pending error blocks a
  // second take too, so a request held over the answer edge is answered once
  assign req      = cyc_i && stb_i && !ack_reg && !err_o;
  assign hit_gate = adr_i == power_off_control_two_off;
  assign hit_one  = adr_i == display_control_one_off;
  assign hit_two  = adr_i == display_control_two_off;
  assign hit_port = adr_i == port_segment_select_off;
  assign hit_sys  = adr_i == system_control_two_off;
  assign hit_stat = adr_i == status_off;
  assign hit_any  = hit_gate || hit_one || hit_two || hit_port || hit_sys || hit_stat;
  assign wr_stb   = req && we_i && hit_any;
  assign lane0_wr = wr_stb && sel_i[0];

  // per-register write strobes; byte registers live on lane 0 only
  assign gate_we  = lane0_wr && hit_gate;
  assign one_we   = lane0_wr && hit_one;
  assign two_we   = lane0_wr && hit_two;
  assign sys_we   = lane0_wr && hit_sys;
  assign port_we  = wr_stb && hit_port;

  // ==========================================================
  // registers
  logic [7:0]  gate_q;
  logic [7:0]  ctl_one_q;
  logic [7:0]  ctl_two_q;
  logic [7:0]  sys_q;
  logic        low_power_entry;
  logic [7:0]  ctl_one_clr;
  logic [SEG_PINS-1:0] port_sel_reg;

  // mode inputs are levels: the clear repeats every cycle a mode stands, so a racing write loses
  // deep idle, deep sleep and stop mode clear
  assign low_power_entry = deep_idle_mode_i || deep_sleep_mode_i || stop_mode_i;
  assign ctl_one_clr     = low_power_entry ? (8'h01 << enable_bit) : 8'h00;

  lcd_reg_word #(.WIDTH(8), .RST(8'h00), .WMASK(8'h01)) u_gate
  (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .we_i     (gate_we),
    .wdata_i  (dat_i[7:0]),
    .hw_clr_i (8'h00),
    .q_o      (gate_q)
  );

  lcd_reg_word #(.WIDTH(8), .RST(control_one_rst), .WMASK(8'hFF)) u_one
  (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .we_i     (one_we),
    .wdata_i  (dat_i[7:0]),
    .hw_clr_i (ctl_one_clr),
    .q_o      (ctl_one_q)
  );

  lcd_reg_word #(.WIDTH(8), .RST(control_two_rst), .WMASK(ctl_two_rd_mask)) u_two
  (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .we_i     (two_we),
    .wdata_i  (dat_i[7:0]),
    .hw_clr_i (8'h00),
    .q_o      (ctl_two_q)
  );

  lcd_reg_word #(.WIDTH(8), .RST(sysctl_rst), .WMASK(8'h07)) u_sys
  (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .we_i     (sys_we),
    .wdata_i  (dat_i[7:0]),
    .hw_clr_i (8'h00),
    .q_o      (sys_q)
  );

  // port select: one bit per shared pin, byte lanes honoured
  // pins beyond bit 31 have no bus lane and stay ports
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      port_sel_reg <= '0;
    else if (port_we)
    begin
      for (int i = 0; i < SEG_PINS && i < 32; i++)
        if (sel_i[i/8])
          port_sel_reg[i] <= dat_i[i];
    end
  end

  // ==========================================================
  // fields
  logic        gate_on;
  logic        enable_bit_q;
  logic [3:0]  slf;
  logic [2:0]  duty;
  logic        bias_internal;
  logic        clk_ok;
  logic        display_on;

  assign gate_on       = gate_q[gate_bit];
  assign enable_bit_q  = ctl_one_q[enable_bit];
  assign slf           = ctl_one_q[slf_lsb +: slf_w];
  assign duty          = ctl_one_q[duty_lsb +: duty_w];
  assign bias_internal = ctl_two_q[bias_sel_bit];

  assign clk_ok = (slf_is_gear(slf) && high_clk_running_i) || (slf_is_low(slf) && low_clk_running_i);

  // the enable bit keeps reading one while blanked by the gate or a stopped clock, so software sees what it wrote; a low-power mode clears it
  // enable drives display
  assign display_on = enable_bit_q && gate_on && clk_ok;

  // ==========================================================
  // driver outputs
  // plain AND: a gate write in mid-phase can clip one base pulse, which is
  // why software leaves the gate alone while the driver runs
  // clock gate
  assign driver_clk_o = base_clk_i & gate_on;

  logic        supply_reg;
  logic        active_reg;
  logic [2:0]  method_reg;
  logic        method_ok_reg;

  // reserved codes pass through with valid low; the core idles on them
  // five methods
  assign drive_method_valid_o = method_ok_reg;
  assign drive_method_o       = method_reg;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      supply_reg    <= 1'b0;
      active_reg    <= 1'b0;
      method_reg    <= quarter_third;
      method_ok_reg <= 1'b1;
    end
    else
    begin
      supply_reg    <= enable_bit_q && !low_power_entry;
      active_reg    <= display_on && !low_power_entry;
      method_reg    <= duty;
      method_ok_reg <= duty <= static_drive;
    end
  end

  assign drive_supply_on_o = supply_reg;
  assign display_active_o  = active_reg;
  assign base_sel_o        = slf;
  assign low_res_time_o    = ctl_two_q[lrse_lsb +: lrse_w];
  assign high_res_sel_o    = ctl_two_q[brh_bit];
  assign internal_bias_o   = bias_internal;

  // ==========================================================
  // pin muxing
  // common pins
  assign com_o = active_reg ? com_wave_i : '0;

  // pins handed to the segments are always driven, low while blank
  // shared segment pins
  genvar g;
  generate
    for (g = 0; g < SEG_PINS; g++)
    begin : g_seg
      assign seg_o[g]      = port_sel_reg[g] ? (active_reg & seg_wave_i[g]) : port_out_i[g];
      assign seg_oe_n_o[g] = port_sel_reg[g] ? 1'b0 : port_oe_n_i[g];
    end
    for (g = 0; g < BIAS_PINS; g++)
    begin : g_bias
      localparam int idx = SEG_PINS - BIAS_PINS + g;
      logic use_seg;
      // bias source is decided first: external resistors take the pin whatever the port select says
      // external bias forced
      assign use_seg            = bias_internal && port_sel_reg[idx];
      assign bias_ext_conn_o[g] = !bias_internal;
      assign bias_o[g]          = use_seg ? (active_reg & seg_wave_i[idx]) : bias_port_out_i[g];
      assign bias_oe_n_o[g]     = !bias_internal ? 1'b1 : (use_seg ? 1'b0 : bias_port_oe_n_i[g]);
    end
  endgenerate

  // ==========================================================
  // read back
  logic [31:0] rd_mux;
  logic [31:0] rd_reg;
  logic [31:0] port_rd;
  logic [3:0]  status_bits;

  assign status_bits = {clk_ok, method_ok_reg, supply_reg, active_reg};

  always_comb
  begin
    port_rd = '0;
    for (int i = 0; i < SEG_PINS && i < 32; i++)
      port_rd[i] = port_sel_reg[i];
  end

  assign rd_mux = hit_gate ? {24'h000000, gate_q} :
                  hit_one  ? {24'h000000, ctl_one_q} :
                  hit_two  ? {24'h000000, ctl_two_q & ctl_two_rd_mask} :
                  hit_port ? port_rd :
                  hit_sys  ? {24'h000000, sys_q} :
                  hit_stat ? {28'h0000000, status_bits} :
                             32'h00000000;

  // read data is captured only on a taken read, so it stands until the next one
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_reg <= 1'b0;
      err_o   <= 1'b0;
      rd_reg  <= 32'h00000000;
    end
    else
    begin
      ack_reg <= req && hit_any;
      err_o   <= req && !hit_any;
      rd_reg  <= (req && !we_i) ? rd_mux : rd_reg;
    end
  end

  assign ack_o = ack_reg;
  assign dat_o = rd_reg;

endmodule

// ---- verif/lcd_panel_model.sv ----
// Purpose: passive panel seen from the common and segment pins
// Assumes: a segment only lights while some common is driven
// Notes:   drives nothing back into the block
`timescale 1ns/1ps
module lcd_panel_model
#(
  parameter int COM_PINS = 4,
  parameter int SEG_PINS = 8
)
(
  // pins from the block
  input  wire logic [COM_PINS-1:0] com_i,
  input  wire logic [SEG_PINS-1:0] seg_i,
  // observation
  output logic                     lit_o
);
  // ====================
  // dark when commons low
  assign lit_o = |com_i && |seg_i;
endmodule

// ---- verif/lcd_enable_monitor.sv ----
// Purpose: port checker for the display enable control block
// Assumes: one clock, synchronous active-high reset
// Notes:   bound into every instance of the block
`timescale 1ns/1ps
module lcd_enable_monitor
#(
  parameter int COM_PINS = 4
)
(
  // clock, reset and bus
  input wire logic                clk_i,
  input wire logic                rst_i,
  input wire logic                cyc_i,
  input wire logic                stb_i,
  input wire logic                ack_o,
  input wire logic                err_o,
  // clock controller
  input wire logic                deep_idle_mode_i,
  input wire logic                deep_sleep_mode_i,
  input wire logic                stop_mode_i,
  input wire logic                high_clk_running_i,
  input wire logic                base_clk_i,
  // driver side
  input wire logic                driver_clk_o,
  input wire logic                drive_supply_on_o,
  input wire logic                display_active_o,
  input wire logic [2:0]          drive_method_o,
  input wire logic                drive_method_valid_o,
  input wire logic [3:0]          base_sel_o,
  input wire logic [COM_PINS-1:0] com_wave_i,
  input wire logic [COM_PINS-1:0] com_o
);
  // ====================
  // properties
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire low_power = deep_idle_mode_i | deep_sleep_mode_i | stop_mode_i;
  sequence s_req;
    cyc_i && stb_i && !ack_o && !err_o;
  endsequence
  sequence s_blank;
    !drive_supply_on_o && !display_active_o;
  endsequence
  property p_answer;
    s_req |=> ack_o ^ err_o;
  endproperty
  property p_clk_gate;
    driver_clk_o |-> base_clk_i;
  endproperty
  property p_reset_state;
    $fell(rst_i) |-> !drive_supply_on_o && !display_active_o && com_o == '0;
  endproperty
  property p_low_power;
    low_power |=> s_blank;
  endproperty
  property p_active_supply;
    display_active_o |-> drive_supply_on_o;
  endproperty
  property p_com;
    com_o == (display_active_o ? com_wave_i : '0);
  endproperty
  property p_gear_clock;
    display_active_o && $past(base_sel_o) <= 4'h6 |-> $past(high_clk_running_i);
  endproperty
  property p_method;
    drive_method_valid_o == (drive_method_o <= 3'h4);
  endproperty
  a_answer: assert property (p_answer) else $error("request not answered next cycle");
  a_clk_gate: assert property (p_clk_gate) else $error("driver clock without base clock");
  a_reset_state: assert property (p_reset_state) else $error("display not off after reset");
  a_low_power: assert property (p_low_power) else $error("display on in low-power mode");
  a_active_supply: assert property (p_active_supply) else $error("display on without supply");
  a_com: assert property (p_com) else $error("common pins wrong");
  a_gear_clock: assert property (p_gear_clock) else $error("display on with high clock off");
  a_method: assert property (p_method) else $error("method valid flag wrong");
endmodule

bind lcd_enable_ctrl lcd_enable_monitor #(.COM_PINS(COM_PINS)) i_mon (.*);

// ---- verif/lcd_driver_enable_control_tb.sv ----
// Purpose: self-checking bench for the display enable control block
// Assumes: 25 MHz clock, one-cycle bus answer
// Notes:   narrow pin counts keep the port select in one byte
`timescale 1ns/1ps
module lcd_driver_enable_control_tb
  import lcd_ctrl_pkg::*;
;
  localparam int COM_PINS  = 4;
  localparam int SEG_PINS  = 8;
  localparam int BIAS_PINS = 2;
  // ====================
  // signals
  logic                 clk_i = 1'h0, rst_i = 1'h1, base_clk_i = 1'h0;
  logic                 cyc_i = 1'h0, stb_i = 1'h0, we_i = 1'h0;
  logic [7:0]           adr_i = 8'h00;
  logic [3:0]           sel_i = 4'h0;
  logic [31:0]          dat_i = 32'h0, dat_o, rd_q;
  logic                 ack_o, err_o, rd_e, lit, high_res_sel_o;
  logic                 deep_idle_mode_i = 1'h0, deep_sleep_mode_i = 1'h0, stop_mode_i = 1'h0;
  logic                 high_clk_running_i = 1'h1, low_clk_running_i = 1'h0;
  logic                 driver_clk_o, drive_supply_on_o, display_active_o, drive_method_valid_o, internal_bias_o;
  logic [2:0]           drive_method_o, low_res_time_o;
  logic [3:0]           base_sel_o;
  logic [COM_PINS-1:0]  com_wave_i = 4'hA, com_o;
  logic [SEG_PINS-1:0]  seg_wave_i = 8'h5A, port_out_i = 8'h3C, port_oe_n_i = 8'hF0, seg_o, seg_oe_n_o;
  logic [BIAS_PINS-1:0] bias_port_out_i = 2'h1, bias_port_oe_n_i = 2'h2, bias_o, bias_oe_n_o, bias_ext_conn_o;
  int                   n_mismatch = 0, checks_done = 0;

  lcd_enable_ctrl #(.SEG_PINS(SEG_PINS), .COM_PINS(COM_PINS), .BIAS_PINS(BIAS_PINS)) i_dut
  (
    .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .err_o,
    .deep_idle_mode_i, .deep_sleep_mode_i, .stop_mode_i, .high_clk_running_i, .low_clk_running_i,
    .base_clk_i, .driver_clk_o, .drive_supply_on_o, .display_active_o, .drive_method_o,
    .drive_method_valid_o, .base_sel_o, .low_res_time_o, .high_res_sel_o, .internal_bias_o,
    .com_wave_i, .seg_wave_i, .com_o, .port_out_i, .port_oe_n_i, .seg_o, .seg_oe_n_o,
    .bias_port_out_i, .bias_port_oe_n_i, .bias_o, .bias_oe_n_o, .bias_ext_conn_o
  );
  lcd_panel_model #(.COM_PINS(COM_PINS), .SEG_PINS(SEG_PINS)) i_panel (.com_i(com_o), .seg_i(seg_o), .lit_o(lit));

  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) base_clk_i <= ~base_clk_i;

  // ====================
  // tasks; every task starts and ends just after a rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // request held until the edge that samples ack or err
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
    cyc_i <= 1'h1;
    stb_i <= 1'h1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= s;
    do
    begin
      @(posedge clk_i);
    end
    while (ack_o !== 1'h1 && err_o !== 1'h1);
    rd_q = dat_o;
    rd_e = err_o;
    cyc_i <= 1'h0;
    stb_i <= 1'h0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    wb(a, 1'h0, 32'h0, 4'hF);
    chk(rd_q[7:0], exp);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    tick(20000);
    n_mismatch++;
    end_sim;
  end

  // ====================
  // tests
  initial
  begin
    tick(4);
    rst_i <= 1'h0;
    tick(1);
    chk({display_active_o, drive_supply_on_o, com_o, driver_clk_o}, 7'h00);
    chk({seg_o, seg_oe_n_o, bias_ext_conn_o, bias_oe_n_o}, {port_out_i, port_oe_n_i, 4'hF});
    for (int i = 0; i < 5; i++)
      rd(8'(i * 4), 8'h00);
    rd(status_off, 8'h0C);
    wb(8'h18, 1'h1, 32'hFF, 4'hF);
    chk(rd_e, 1'h1);
    wb(power_off_control_two_off, 1'h1, 32'h1, 4'hF);
    for (int i = 0; i < 2; i++)
    begin
      chk(driver_clk_o, base_clk_i);
      tick(1);
    end
    for (int m = 0; m < 8; m++)
    begin
      wb(display_control_one_off, 1'h1, {24'h0, 1'h1, 3'(m), 4'h0}, 4'hF);
      tick(1);
      chk({drive_method_o, drive_method_valid_o}, {3'(m), m < 5});
      rd(display_control_one_off, {1'h1, 3'(m), 4'h0});
    end
    wb(display_control_one_off, 1'h1, 32'h80, 4'hF);
    wb(port_segment_select_off, 1'h1, 32'hFF, 4'hF);
    wb(port_segment_select_off, 1'h1, 32'h00, 4'h0);
    rd(port_segment_select_off, 8'hFF);
    chk({display_active_o, drive_supply_on_o, com_o, lit}, 7'h75);
    chk({seg_o, seg_oe_n_o}, {seg_wave_i, 8'h00});
    wb(display_control_two_off, 1'h1, 32'hFF, 4'hF);
    rd(display_control_two_off, 8'hF8);
    chk({internal_bias_o, bias_ext_conn_o}, 3'h4);
    chk({bias_o, bias_oe_n_o}, {seg_wave_i[SEG_PINS-1 -: BIAS_PINS], 2'h0});
    wb(display_control_two_off, 1'h1, 32'hAF, 4'hF);
    chk({low_res_time_o, high_res_sel_o, internal_bias_o}, 5'h15);
    wb(display_control_one_off, 1'h1, 32'h00, 4'hF);
    tick(1);
    chk({display_active_o, drive_supply_on_o, com_o, seg_o, seg_oe_n_o, lit}, 23'h0);
    port_out_i <= 8'hC3;
    wb(port_segment_select_off, 1'h1, 32'h00, 4'hF);
    wb(display_control_two_off, 1'h1, 32'h00, 4'hF);
    chk({seg_o, seg_oe_n_o, bias_ext_conn_o, bias_oe_n_o}, {8'hC3, port_oe_n_i, 4'hF});
    high_clk_running_i <= 1'h0;
    wb(display_control_one_off, 1'h1, 32'h80, 4'hF);
    rd(display_control_one_off, 8'h80);
    chk(display_active_o, 1'h0);
    high_clk_running_i <= 1'h1;
    tick(2);
    chk(display_active_o, 1'h1);
    wb(display_control_one_off, 1'h1, 32'h88, 4'hF);
    rd(display_control_one_off, 8'h88);
    chk(display_active_o, 1'h0);
    low_clk_running_i <= 1'h1;
    tick(2);
    chk(display_active_o, 1'h1);
    wb(power_off_control_two_off, 1'h1, 32'h0, 4'hF);
    rd(display_control_one_off, 8'h88);
    chk({display_active_o, driver_clk_o}, 2'h0);
    wb(power_off_control_two_off, 1'h1, 32'h1, 4'hF);
    tick(1);
    chk(display_active_o, 1'h1);
    for (int k = 0; k < 3; k++)
    begin
      {stop_mode_i, deep_sleep_mode_i, deep_idle_mode_i} <= 3'(1 << k);
      tick(2);
      {stop_mode_i, deep_sleep_mode_i, deep_idle_mode_i} <= 3'h0;
      chk({display_active_o, drive_supply_on_o}, 2'h0);
      rd(display_control_one_off, 8'h08);
      wb(display_control_one_off, 1'h1, 32'h88, 4'hF);
      tick(1);
      chk(display_active_o, 1'h1);
    end
    wb(display_control_one_off, 1'h1, 32'h08, 4'hF);
    wb(display_control_one_off, 1'h1, 32'h82, 4'hF);
    tick(1);
    chk({display_active_o, base_sel_o}, 5'h12);
    wb(display_control_one_off, 1'h1, 32'h02, 4'hF);
    wb(display_control_one_off, 1'h1, 32'h89, 4'hF);
    tick(1);
    chk({display_active_o, base_sel_o}, 5'h19);
    wb(display_control_one_off, 1'h1, 32'h09, 4'hF);
    wb(power_off_control_two_off, 1'h1, 32'h0, 4'hF);
    chk({display_active_o, driver_clk_o, drive_supply_on_o}, 3'h0);
    rst_i <= 1'h1;
    tick(2);
    rst_i <= 1'h0;
    tick(1);
    chk({display_active_o, com_o, bias_ext_conn_o}, 7'h03);
    rd(display_control_one_off, 8'h00);
    end_sim;
  end
endmodule
